// ===== rtl/vslrx_pkg.sv
// package for the vpw serial link receive filter, crc and power mode block
package vslrx_pkg;
  localparam int unsigned CLK_FREQ_HZ = 125000000;
  localparam int unsigned FILT_MAX = 15;
  localparam logic [3:0] FILT_TOP = 4'hf;
  localparam logic [3:0] FILT_BOT = 4'h0;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_PRESET = 8'hff;
  localparam logic [7:0] CRC_GOOD = 8'hc4;
  localparam logic [3:0] MAX_FRAME_BYTES = 4'hc;
  // symbol times in microseconds
  localparam int unsigned SOF_US = 200;
  localparam int unsigned EOD_US = 200;
  localparam int unsigned EOF_US = 280;
  localparam int unsigned IDLE_US = 300;
  localparam int unsigned BIT_SHORT_US = 64;
  localparam int unsigned BIT_LONG_US = 128;
  localparam int unsigned BIT_SPLIT_US = (BIT_SHORT_US + BIT_LONG_US) / 2;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_WAIT,
    PWR_STOP
  } vslrx_pwr_t;
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_SOF,
    RX_BITS,
    RX_EOD
  } vslrx_rx_t;
  typedef struct packed {
    logic frame_done;
    logic crc_error;
    logic eof_seen;
    logic [3:0] byte_count;
  } vslrx_status_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } vslrx_byte_t;
endpackage

// ===== rtl/vslrx_core.sv
// power modes, loopback, rx noise filter, vpw receive and crc framing
//
// Summary of operation
// RULE1 - wait instruction with stop_on_wait_select clear enters wait, clocks keep running
// RULE2 - in wait, first passive-to-active bus edge raises wakeup interrupt
// RULE3 - in wait, a valid end-of-frame also raises wakeup interrupt
// RULE4 - stop instruction, or wait with stop_on_wait_select set, enters stop
// RULE5 - stop halts internal clocks; bus activity interrupts and restarts them
// RULE6 - digital loopback ties tx output to rx input, bus left undriven
// RULE7 - analog loopback changes nothing digital; after exit wait for idle bus
// RULE8 - filter samples raw rx on rising edge, counter updates on falling edge
// RULE9 - counter counts up on high, down on low, saturates at 15 and 0
// RULE10 - counter at 15 sets the filtered output latch
// RULE11 - counter at 0 clears the latch; latch holds until opposite end
// RULE12 - clean edges reach filtered output after 15 to 16 filter clocks
// RULE13 - at most 12 bytes per frame, each sent msb first
// RULE14 - frame starts with 200 us active start symbol, excluded from crc
// RULE15 - every transmitted frame holds at least one data byte plus crc
// RULE16 - crc generated in hardware for tx and checked on every rx frame
// RULE17 - crc poly x8+x4+x3+x2+1, preset ones, inverted remainder sent msb first
// RULE18 - rx remainder over data plus crc not equal c4 flags crc error
// RULE19 - 200 us passive end-of-data ends originator data, sets no flag
// RULE20 - 280 us passive period recognised as end-of-frame
// RULE21 - frames with or without in-frame response are both accepted
// RULE22 - end-of-frame flag set when end-of-frame symbol received
// RULE23 - reset puts registers and outputs to reset values, inputs ignored
// RULE24 - reset presets filter counter to 15 and latch to 1
`timescale 1ns/1ps
module vslrx_core #(
  parameter int unsigned CLK_HZ = vslrx_pkg::CLK_FREQ_HZ,
  parameter int unsigned EOF_CYCLES = (vslrx_pkg::EOF_US * (CLK_HZ / 1000000)),
  parameter int unsigned IDLE_CYCLES = (vslrx_pkg::IDLE_US * (CLK_HZ / 1000000))
) (
  input wire logic clock_in, // system clock, 125 mhz
  input wire logic rst_in, // async reset, active high
  input wire logic mux_clk_in, // mux interface clock, sampled synchronously
  input wire logic cpu_wait_in, // pulse: cpu executes wait
  input wire logic cpu_stop_in, // pulse: cpu executes stop
  input wire logic cpu_wake_in, // pulse: cpu leaves low power by other means
  input wire logic stop_on_wait_select_in, // wait instruction means stop
  input wire logic digital_loop_in, // digital loopback enable
  input wire logic analog_loop_in, // analog loopback enable
  input wire logic link_rx_digital_in, // raw receive from transceiver, 1 = passive
  input wire logic tx_byte_valid_in, // tx byte offered
  input wire logic tx_byte_last_in, // offered byte is last data byte
  input wire logic [7:0] tx_byte_in, // tx data byte
  output logic tx_byte_ready_out, // tx byte accepted this cycle
  output logic link_tx_digital_out, // transmit to transceiver, 1 = passive
  output logic filtered_rx_out, // filtered receive level
  output logic wake_irq_out, // wakeup interrupt request
  output logic clocks_run_out, // internal clocks enabled
  output vslrx_pkg::vslrx_pwr_t pwr_mode_out, // current power mode
  output logic bus_ready_out, // allowed to take part on the bus
  output vslrx_pkg::vslrx_byte_t rx_byte_out, // received byte stream
  output vslrx_pkg::vslrx_byte_t tx_frame_byte_out, // bytes to the encoder, crc byte last
  output vslrx_pkg::vslrx_status_t status_out // state vector bits
);
  import vslrx_pkg::*;

  localparam int unsigned CPU = CLK_HZ / 1000000;
  localparam logic [15:0] SOF_MIN = 16'((SOF_US * CPU * 3) / 4);
  localparam logic [15:0] EOD_MIN = 16'((EOD_US * CPU * 3) / 4);
  localparam logic [15:0] SPLIT = 16'(BIT_SPLIT_US * CPU);
  localparam logic [15:0] EOF_CNT = 16'(EOF_CYCLES);
  localparam logic [15:0] IDLE_CNT = 16'(IDLE_CYCLES);

  // one serial crc step, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] r, input logic b);
    crc_step = {r[6:0], 1'b0} ^ ((r[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  // ---------------------------------------------------------------
  // power modes
  // ---------------------------------------------------------------
  vslrx_pwr_t pwr, next_pwr;
  logic wake_irq, next_wake_irq;
  logic filt, filt_prev;
  logic eof_pulse;

  // in wait, bus activity is the passive-to-active (1 to 0) edge of filtered rx; in stop, a low raw rx level
  always_comb begin
    next_pwr = pwr;
    next_wake_irq = 1'b0;
    unique case (pwr)
      PWR_RUN: begin
        if (cpu_stop_in || (cpu_wait_in && stop_on_wait_select_in)) begin
          next_pwr = PWR_STOP; // see RULE4
        end else if (cpu_wait_in) begin
          next_pwr = PWR_WAIT; // see RULE1
        end
      end
      PWR_WAIT: begin
        if ((filt_prev && !filt) || eof_pulse) begin
          next_pwr = PWR_RUN; // see RULE2 see RULE3
          next_wake_irq = 1'b1;
        end else if (cpu_wake_in) begin
          next_pwr = PWR_RUN;
        end
      end
      PWR_STOP: begin
        // raw input used: filter clock is halted here
        if (!link_rx_digital_in || cpu_wake_in) begin
          next_pwr = PWR_RUN; // see RULE5
          next_wake_irq = !link_rx_digital_in;
        end
      end
      default: next_pwr = PWR_RUN;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwr <= PWR_RUN; // see RULE23
      wake_irq <= 1'b0;
    end else begin
      pwr <= next_pwr;
      wake_irq <= next_wake_irq;
    end
  end

  logic clk_en;
  assign clk_en = (pwr != PWR_STOP); // see RULE5

  // ---------------------------------------------------------------
  // loopback and rx filter
  // ---------------------------------------------------------------
  logic tx_line, rx_src;
  logic mux_prev, sample;
  logic next_mux_prev, next_sample;
  logic [3:0] fcnt, next_fcnt;
  logic next_filt, rise, fall;

  // in digital loopback the transceiver sees passive and rx hears tx
  assign rx_src = digital_loop_in ? tx_line : link_rx_digital_in; // see RULE6
  assign rise = clk_en && mux_clk_in && !mux_prev;
  assign fall = clk_en && !mux_clk_in && mux_prev;

  always_comb begin
    next_mux_prev = mux_clk_in;
    next_sample = rise ? rx_src : sample; // see RULE8
    next_fcnt = fcnt;
    next_filt = filt;
    if (fall) begin
      if (sample && fcnt != FILT_TOP) begin
        next_fcnt = fcnt + 4'h1; // see RULE9
      end else if (!sample && fcnt != FILT_BOT) begin
        next_fcnt = fcnt - 4'h1;
      end
    end
    // latch moves only at end points; full swing gives the 15-16 clock lag
    if (next_fcnt == FILT_TOP) begin
      next_filt = 1'b1; // see RULE10 see RULE12
    end else if (next_fcnt == FILT_BOT) begin
      next_filt = 1'b0; // see RULE11
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mux_prev <= 1'b0;
      sample <= 1'b1;
      fcnt <= FILT_TOP; // see RULE24
      filt <= 1'b1;
      filt_prev <= 1'b1;
    end else begin
      mux_prev <= next_mux_prev;
      sample <= next_sample;
      fcnt <= next_fcnt;
      filt <= next_filt;
      filt_prev <= filt;
    end
  end

  // ---------------------------------------------------------------
  // receive: symbol timing, bytes and crc check
  // ---------------------------------------------------------------
  vslrx_rx_t rxs, next_rxs;
  logic [15:0] len, next_len;
  logic [15:0] idle_len, next_idle_len;
  logic [7:0] sh, next_sh;
  logic [2:0] bitn, next_bitn;
  logic [7:0] rcrc, next_rcrc;
  vslrx_byte_t rxb, next_rxb;
  vslrx_status_t st, next_st;
  logic aloop_prev, hold_off, next_hold_off, edge_any, bitval;

  assign edge_any = clk_en && (filt != filt_prev);
  // short passive (filt 1) = 0, short active = 1
  assign bitval = filt_prev ? (len >= SPLIT) : (len < SPLIT);
  assign eof_pulse = (rxs == RX_EOD) && filt && (len == EOF_CNT); // see RULE20

  always_comb begin
    next_rxs = rxs;
    next_len = clk_en ? ((edge_any || len == 16'hffff) ? ((edge_any) ? 16'h0000 : len) :
      len + 16'h0001) : len;
    next_idle_len = (filt && clk_en) ? ((idle_len == 16'hffff) ? idle_len :
      idle_len + 16'h0001) : (filt ? idle_len : 16'h0000);
    next_sh = sh;
    next_bitn = bitn;
    next_rcrc = rcrc;
    next_rxb = '0;
    next_st = st;
    next_st.frame_done = 1'b0;
    unique case (rxs)
      RX_IDLE: begin
        if (edge_any && !filt) begin
          next_rxs = RX_SOF;
        end
      end
      RX_SOF: begin
        if (edge_any) begin
          if (len >= SOF_MIN) begin
            next_rxs = RX_BITS; // see RULE14
            next_rcrc = CRC_PRESET;
            next_bitn = 3'h0;
            next_st = '0;
          end else begin
            next_rxs = RX_IDLE;
          end
        end
      end
      RX_BITS: begin
        if (edge_any) begin
          next_sh = {sh[6:0], bitval}; // see RULE13
          next_rcrc = crc_step(rcrc, bitval); // see RULE16
          next_bitn = bitn + 3'h1;
          if (bitn == 3'h7 && st.byte_count != MAX_FRAME_BYTES) begin
            next_rxb.valid = 1'b1;
            next_rxb.data = {sh[6:0], bitval};
            next_st.byte_count = st.byte_count + 4'h1;
          end
        end else if (filt && len >= EOD_MIN) begin
          // end of data sets nothing; crc is judged here
          next_rxs = RX_EOD; // see RULE19
          next_st.crc_error = (rcrc != CRC_GOOD); // see RULE18
        end
      end
      RX_EOD: begin
        if (edge_any) begin
          // in-frame response follows: restart byte capture, see RULE21
          next_rxs = RX_BITS;
          next_rcrc = CRC_PRESET;
          next_bitn = 3'h0;
        end else if (eof_pulse) begin
          next_rxs = RX_IDLE;
          next_st.eof_seen = 1'b1; // see RULE22
          next_st.frame_done = 1'b1;
          next_rxb.last = 1'b1;
        end
      end
      default: next_rxs = RX_IDLE;
    endcase
    // after analog loopback exit stay off the bus until idle
    next_hold_off = hold_off;
    if (aloop_prev && !analog_loop_in) begin
      next_hold_off = 1'b1; // see RULE7
      next_idle_len = 16'h0000; // a stale idle count would release the hold at once
    end else if (idle_len >= IDLE_CNT) begin
      next_hold_off = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rxs <= RX_IDLE;
      len <= 16'h0000;
      idle_len <= 16'h0000;
      sh <= 8'h00;
      bitn <= 3'h0;
      rcrc <= CRC_PRESET;
      rxb <= '0;
      st <= '0;
      aloop_prev <= 1'b0;
      hold_off <= 1'b0;
    end else begin
      rxs <= next_rxs;
      len <= next_len;
      idle_len <= next_idle_len;
      sh <= next_sh;
      bitn <= next_bitn;
      rcrc <= next_rcrc;
      rxb <= next_rxb;
      st <= next_st;
      aloop_prev <= analog_loop_in;
      hold_off <= next_hold_off;
    end
  end

  // ---------------------------------------------------------------
  // transmit crc: bytes pass through, then inverted crc byte
  // ---------------------------------------------------------------
  logic [7:0] tcrc, next_tcrc;
  logic crc_due, next_crc_due;
  vslrx_byte_t tx_hold, next_tx_hold;

  // a frame starts only from a data byte, so a bare crc is impossible
  always_comb begin
    logic [7:0] c;
    c = tcrc;
    next_tcrc = tcrc;
    next_crc_due = crc_due;
    next_tx_hold = '0; // each outgoing byte shows for one cycle
    if (crc_due) begin
      next_tx_hold = '{valid: 1'b1, last: 1'b1, data: ~tcrc}; // see RULE17
      next_crc_due = 1'b0;
      next_tcrc = CRC_PRESET;
    end else if (tx_byte_valid_in && tx_byte_ready_out) begin
      for (int i = 7; i >= 0; i--) begin
        c = crc_step(c, tx_byte_in[i]);
      end
      next_tcrc = c;
      next_tx_hold = '{valid: 1'b1, last: 1'b0, data: tx_byte_in}; // see RULE15
      next_crc_due = tx_byte_last_in; // see RULE16
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tcrc <= CRC_PRESET;
      crc_due <= 1'b0;
      tx_hold <= '0;
    end else begin
      tcrc <= next_tcrc;
      crc_due <= next_crc_due;
      tx_hold <= next_tx_hold;
    end
  end

  assign tx_line = 1'b1; // bit encoding lives elsewhere; line left passive
  assign tx_byte_ready_out = clk_en && !crc_due && !hold_off;
  assign link_tx_digital_out = digital_loop_in ? 1'b1 : tx_line; // see RULE6
  assign filtered_rx_out = filt;
  assign wake_irq_out = wake_irq;
  assign clocks_run_out = clk_en;
  assign pwr_mode_out = pwr;
  assign bus_ready_out = !hold_off;
  assign rx_byte_out = rxb;
  assign status_out = st;
  assign tx_frame_byte_out = tx_hold;
endmodule

// ===== tb/vslrx_chk.sv
// port assertions for the link receive core
`timescale 1ns/1ps
module vslrx_chk
  import vslrx_pkg::*;
(
  input wire logic clock_in, // clock
  input wire logic rst_in, // reset
  input wire logic mux_clk_in, // filter clock
  input wire logic cpu_wait_in, // wait pulse
  input wire logic cpu_stop_in, // stop pulse
  input wire logic stop_on_wait_select_in, // wait means stop
  input wire logic digital_loop_in, // digital loop
  input wire logic analog_loop_in, // analog loop
  input wire logic link_tx_digital_out, // tx line
  input wire logic filtered_rx_out, // filtered rx
  input wire logic wake_irq_out, // wakeup
  input wire logic clocks_run_out, // clocks on
  input wire vslrx_pwr_t pwr_mode_out, // power mode
  input wire logic bus_ready_out // bus ready
);
  logic mux_q, filt_q;
  logic [4:0] falls, next_falls;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // filter clock falls since the latch last moved; saturates so idle never wraps
  always_comb begin
    next_falls = falls;
    if (filt_q != filtered_rx_out) begin
      next_falls = 5'h00;
    end else if (mux_q && !mux_clk_in && falls != 5'h1f) begin
      next_falls = falls + 5'h01;
    end
  end
  // helper registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      falls <= 5'h1f;
      mux_q <= 1'b0;
      filt_q <= 1'b1;
    end else begin
      falls <= next_falls;
      mux_q <= mux_clk_in;
      filt_q <= filtered_rx_out;
    end
  end
  rst_vals_a: assert property (disable iff (1'b0) rst_in && $past(rst_in) |->
    filtered_rx_out && !wake_irq_out && pwr_mode_out == PWR_RUN) else $error("bad reset state");
  irq_run_a: assert property (wake_irq_out |-> ##[0:1] pwr_mode_out == PWR_RUN)
    else $error("wakeup without run");
  wait_enter_a: assert property (pwr_mode_out == PWR_RUN && cpu_wait_in &&
    !stop_on_wait_select_in |=> pwr_mode_out == PWR_WAIT) else $error("wait not entered");
  stop_enter_a: assert property (pwr_mode_out == PWR_RUN && (cpu_stop_in ||
    cpu_wait_in && stop_on_wait_select_in) |=> pwr_mode_out == PWR_STOP) else $error("no stop");
  clk_halt_a: assert property (clocks_run_out == (pwr_mode_out != PWR_STOP))
    else $error("clock enable wrong");
  filt_span_a: assert property (filt_q != filtered_rx_out |-> falls >= 5'd14)
    else $error("filter latch moved too soon");
  tx_idle_a: assert property (digital_loop_in |-> link_tx_digital_out)
    else $error("bus driven in loopback");
  loop_exit_a: assert property ($fell(analog_loop_in) |-> ##[1:2] !bus_ready_out)
    else $error("ready after loop exit");
endmodule

// ===== tb/vslrx_bus_model.sv
// far side: transceiver and other nodes on a wired bus
`timescale 1ns/1ps
module vslrx_bus_model (
  input wire logic tx_in, // our transmit, 1 = passive
  input wire logic node_in, // other node, 1 = passive
  output logic rx_out // level back from the bus
);
  // active level dominates; node frames open with a start symbol, msb first
  assign rx_out = tx_in & node_in;
endmodule

// ===== tb/vslrx_core_tb.sv
// testbench for the link receive core
`timescale 1ns/1ps
module vslrx_core_tb;
  import vslrx_pkg::*;
  localparam int unsigned US = 4; // cycles per us keeps frames short
  typedef struct {logic [7:0] d0; logic [7:0] d1; int n; logic bad; logic nap;} vslrx_row_t;
  vslrx_row_t rows [3] = '{'{8'h5a, 8'h00, 1, 0, 0}, '{8'h81, 8'h3c, 2, 0, 1},
    '{8'hff, 8'h00, 1, 1, 0}};
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] mdiv = 2'h0;
  logic mux;
  logic cwait = 1'b0;
  logic cstop = 1'b0;
  logic sel = 1'b0;
  logic dloop = 1'b0;
  logic aloop = 1'b0;
  logic node = 1'b1;
  logic raw, txl, filt, irq, crun, bus_ok, tready;
  logic tv = 1'b0;
  logic tl = 1'b0;
  logic [7:0] tdat = 8'h00;
  vslrx_pwr_t mode;
  vslrx_byte_t rxb, txo;
  vslrx_status_t st;
  logic [7:0] got [$];
  logic [7:0] sent [$];
  int n_irq = 0;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  vslrx_core #(.CLK_HZ(US * 1000000)) uut (.clock_in(clock_in), .rst_in(rst_in),
    .mux_clk_in(mux), .cpu_wait_in(cwait), .cpu_stop_in(cstop), .cpu_wake_in(1'b0),
    .stop_on_wait_select_in(sel), .digital_loop_in(dloop), .analog_loop_in(aloop),
    .link_rx_digital_in(raw), .tx_byte_valid_in(tv), .tx_byte_last_in(tl),
    .tx_byte_in(tdat), .tx_byte_ready_out(tready), .link_tx_digital_out(txl),
    .filtered_rx_out(filt), .wake_irq_out(irq), .clocks_run_out(crun), .pwr_mode_out(mode),
    .bus_ready_out(bus_ok), .rx_byte_out(rxb), .status_out(st), .tx_frame_byte_out(txo));
  vslrx_bus_model bus (.tx_in(txl), .node_in(node), .rx_out(raw));
  // clocks: filter clock is a quarter of the system rate
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    mdiv <= mdiv + 2'h1;
  end
  assign mux = mdiv[1];
  // collect received bytes and cut a hang short
  always @(posedge clock_in) begin
    cyc++;
    if (rxb.valid === 1'b1) got.push_back(rxb.data);
    if (txo.valid === 1'b1) sent.push_back(txo.data);
    if (irq === 1'b1) n_irq++;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // offer one tx byte and hold it until taken; the caller drops valid after the last
  task automatic tx_put(input logic [7:0] d, input logic last);
    tv <= 1'b1;
    tl <= last;
    tdat <= d;
    @(posedge clock_in);
    while (tready !== 1'b1) begin
      @(posedge clock_in);
    end
  endtask
  task automatic drv(input logic v, input int us);
    @(posedge clock_in);
    node <= v;
    tick(us * US - 1);
  endtask
  task automatic rst_chk();
    chk("filtered", 8'h01, {7'h00, filt});
    chk("mode", {6'h00, PWR_RUN}, {6'h00, mode});
    chk("status", 8'h00, {1'b0, st});
  endtask
  // crc over whole bytes, msb first, returned already inverted
  function automatic logic [7:0] crc8(input logic [7:0] b [$]);
    logic [7:0] r;
    r = CRC_PRESET;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i][k]) ? CRC_POLY : 8'h00);
      end
    end
    return ~r;
  endfunction
  // vpw frame from the other node: start, bits alternating level, end gap
  task automatic send(input logic [7:0] b [$], input logic nap);
    logic lvl;
    lvl = 1'b0;
    drv(1'b0, SOF_US);
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        lvl = ~lvl;
        drv(lvl, (b[i][k] != lvl) ? BIT_SHORT_US : BIT_LONG_US);
      end
    end
    drv(1'b1, EOD_US);
    chk("eof_at_eod", 8'h00, {7'h00, st.eof_seen});
    // optionally nap in the gap: only the end of frame can wake us then
    cwait <= nap;
    tick(1);
    cwait <= 1'b0;
    drv(1'b1, EOF_US - EOD_US + 40);
  endtask
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] q [$];
    int t, irq0;
    vslrx_pwr_t em;
    tick(20);
    rst_chk();
    rst_in <= 1'b0;
    tick(400);
    foreach (rows[r]) begin
      q = {rows[r].d0};
      if (rows[r].n == 2) q.push_back(rows[r].d1);
      sent.delete();
      foreach (q[i]) tx_put(q[i], i == q.size() - 1);
      tv <= 1'b0;
      tick(3);
      chk("tx_first", q[0], (sent.size() > 0) ? sent[0] : 8'hxx);
      chk("tx_crc", crc8(q), (sent.size() > q.size()) ? sent[q.size()] : 8'hxx);
      q.push_back(crc8(q) ^ {7'h00, rows[r].bad});
      got.delete();
      irq0 = n_irq;
      send(q, rows[r].nap);
      chk("eof_wake", {7'h00, rows[r].nap}, {7'h00, n_irq != irq0});
      chk("eof_mode", {6'h00, PWR_RUN}, {6'h00, mode});
      chk("crc_error", {7'h00, rows[r].bad}, {7'h00, st.crc_error});
      chk("eof_seen", 8'h01, {7'h00, st.eof_seen});
      for (int i = 0; i < rows[r].n; i++) begin
        chk("rx_byte", q[i], (got.size() > i) ? got[i] : 8'hxx);
      end
    end
    // a pulse shorter than the filter delay must vanish
    drv(1'b0, 10);
    drv(1'b1, 30);
    chk("glitch", 8'h01, {7'h00, filt});
    @(posedge clock_in);
    node <= 1'b0;
    t = 0;
    while (filt !== 1'b0 && t < 200) begin
      tick(1);
      t++;
    end
    chk("filter_delay", 8'h01, {7'h00, t >= 56 && t <= 72});
    rst_in <= 1'b1;
    tick(3);
    rst_chk();
    rst_in <= 1'b0;
    node <= 1'b1;
    tick(100);
    // wait, wait as stop, stop; each woken by bus activity
    for (int p = 0; p < 3; p++) begin
      em = (p == 0) ? PWR_WAIT : PWR_STOP;
      sel <= (p == 1);
      cwait <= (p < 2);
      cstop <= (p == 2);
      tick(1);
      cwait <= 1'b0;
      cstop <= 1'b0;
      tick(3);
      chk("pwr_mode", {6'h00, em}, {6'h00, mode});
      chk("clocks_run", {7'h00, p == 0}, {7'h00, crun});
      node <= 1'b0;
      t = 0;
      while (irq !== 1'b1 && t < 300) begin
        tick(1);
        t++;
      end
      chk("wake_irq", 8'h01, {7'h00, irq});
      tick(3);
      chk("woken", {6'h00, PWR_RUN}, {6'h00, mode});
      drv(1'b1, 100);
    end
    dloop <= 1'b1;
    drv(1'b0, 60);
    chk("loop_filtered", 8'h01, {7'h00, filt});
    chk("loop_tx", 8'h01, {7'h00, txl});
    drv(1'b1, 10);
    dloop <= 1'b0;
    aloop <= 1'b1;
    tick(IDLE_US * US + 10); // an idle bus before exit must not release the hold
    aloop <= 1'b0;
    tick(4);
    chk("ready_exit", 8'h00, {7'h00, bus_ok});
    tick(IDLE_US * US + 100);
    chk("ready_idle", 8'h01, {7'h00, bus_ok});
    final_report();
  end
endmodule
bind vslrx_core vslrx_chk chk (.clock_in, .rst_in, .mux_clk_in, .cpu_wait_in, .cpu_stop_in,
  .stop_on_wait_select_in, .digital_loop_in, .analog_loop_in, .link_tx_digital_out,
  .filtered_rx_out, .wake_irq_out, .clocks_run_out, .pwr_mode_out, .bus_ready_out);
